// *** pkg/rtc_port_pkg.sv ***
// Purpose: shared constants for the rtc host bus strobe and reset block
// Assumes: one 200 MHz clock, byte wide multiplexed host bus
// Notes: register byte map on the host bus and avalon map live here
package rtc_port_pkg;

    // ****************************************
    // host bus register map
    // ****************************************
    localparam logic [7:0] HB_CTRL_ADDR = 8'h0b;
    localparam logic [7:0] HB_FLAG_ADDR = 8'h0c;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] FLAG_RESET = 8'h00;

    // control byte fields
    localparam int PER_IE_BIT = 6;
    localparam int ALM_IE_BIT = 5;
    localparam int UPD_IE_BIT = 4;
    localparam int SQW_EN_BIT = 3;

    // flag byte fields
    localparam int IRQ_FLAG_BIT = 7;
    localparam int PER_FLAG_BIT = 6;
    localparam int ALM_FLAG_BIT = 5;
    localparam int UPD_FLAG_BIT = 4;

    // ****************************************
    // avalon register map (byte addresses)
    // ****************************************
    localparam logic [3:0] AVS_CTRL = 4'h0;
    localparam logic [3:0] AVS_STAT = 4'h4;
    localparam logic [3:0] AVS_INT = 4'h8;
    localparam logic [3:0] AVS_MASK = 4'hc;

    // status word fields above the flag byte
    localparam int STAT_ACCESS_BIT = 8;
    localparam int STAT_STYLE_BIT = 9;
    localparam int STAT_POWER_BIT = 10;
    localparam int STAT_IRQ_BIT = 11;

    // sticky event bits
    localparam int EV_W = 4;
    localparam int EV_WR = 0;
    localparam int EV_RD = 1;
    localparam int EV_RST = 2;
    localparam int EV_IRQ = 3;
    localparam logic [EV_W-1:0] EV_RESET = 4'h0;

    // avalon answer states
    typedef enum logic [1:0] {
        AVS_IDLE = 2'b01,
        AVS_ANSWER = 2'b10
    } avs_state_e;

endpackage

// *** hw/bus_edge_track.sv ***
// Purpose: remembers last host strobe levels and reports their edges
// Assumes: strobes and bus are synchronous to i_mclk
// Notes: edge pulses are one cycle wide and combinational
`timescale 1ns/1ps
module bus_edge_track (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_as,
    input wire logic i_strobe,
    input wire logic i_rw,
    input wire logic [7:0] i_ad,
    output logic o_as_rise,
    output logic o_as_fall,
    output logic o_strobe_rise,
    output logic o_strobe_fall,
    output logic o_rw_rise,
    output logic o_rw_held,
    output logic [7:0] o_ad_held
);

    // ****************************************
    // previous levels
    // ****************************************
    logic as_reg, as_next;
    logic strobe_reg, strobe_next;
    logic rw_reg, rw_next;
    logic [7:0] ad_reg, ad_next;

    always_comb begin
        as_next = i_as;
        strobe_next = i_strobe;
        rw_next = i_rw;
        ad_next = i_ad;
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            as_reg <= 1'b0;
            strobe_reg <= 1'b0;
            rw_reg <= 1'b1;
            ad_reg <= 8'h00;
        end else begin
            as_reg <= as_next;
            strobe_reg <= strobe_next;
            rw_reg <= rw_next;
            ad_reg <= ad_next;
        end
    end

    // ****************************************
    // edge pulses
    // ****************************************
    always_comb begin
        o_as_rise = i_as & ~as_reg;
        o_as_fall = ~i_as & as_reg;
        o_strobe_rise = i_strobe & ~strobe_reg;
        o_strobe_fall = ~i_strobe & strobe_reg;
        o_rw_rise = i_rw & ~rw_reg;
        o_rw_held = rw_reg;
        o_ad_held = ad_reg;
    end

endmodule

// *** hw/rtc_bus_strobe_and_reset.sv ***
// Purpose: host bus strobe handling and reset actions of a real-time clock
// Assumes: host pins synchronous to i_mclk; events arrive as one-cycle pulses
// Notes: avalon slave exposes control, status, sticky events and a mask
//
// Notes on behaviour
// RQ1: bus_style_select high picks data-strobe style, low picks output-enable style.
// RQ2: in data-strobe style the host pulses the strobe high late in each cycle.
// RQ3: data-strobe style read drives the bus only while the strobe is high.
// RQ4: data-strobe style write data is taken on the strobe falling edge.
// RQ5: output-enable style read drives the bus only while the strobe is low.
// RQ6: reset never touches clock, calendar or general ram.
// RQ7: reset with good supply clears periodic, alarm and update interrupt enables.
// RQ8: reset with good supply clears periodic, alarm and request status flags.
// RQ9: reset with good supply releases the interrupt request pin.
// RQ10: bus reads and writes are ignored while reset is low.
// RQ11: reset with good supply clears the square wave enable.
// RQ12: host holds reset over 200 ms when used at power up.
// RQ13: power fail alone changes no control bit; only reset does.
// RQ14: address is latched on the address strobe falling edge.
// RQ15: output-enable style write data is taken on write line rising edge.
// RQ16: host clears a pending request by reading the flag register.
// RQ17: reset input is synchronised before any clearing acts.
//
// The implementer's own choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
module rtc_bus_strobe_and_reset
    import rtc_port_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_bus_style_select,
    input wire logic i_address_latch_strobe,
    input wire logic i_data_read_strobe,
    input wire logic i_read_write,
    input wire logic i_chip_select_n,
    input wire logic i_reset_n,
    input wire logic i_power_ok,
    input wire logic [7:0] i_ad,
    output logic [7:0] o_ad,
    output logic o_ad_oe,
    output logic o_irq_n_out,
    output logic o_irq_n_oe,
    output logic o_square_wave_enable,
    input wire logic i_periodic_event,
    input wire logic i_alarm_event,
    input wire logic i_update_event,
    input wire logic [3:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    output logic o_irq
);

    // ****************************************
    // strobe edges
    // ****************************************
    logic as_rise, as_fall, strb_rise, strb_fall, rw_rise, rw_held;
    logic [7:0] ad_held;

    bus_edge_track u_edges (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_as(i_address_latch_strobe),
        .i_strobe(i_data_read_strobe),
        .i_rw(i_read_write),
        .i_ad(i_ad),
        .o_as_rise(as_rise),
        .o_as_fall(as_fall),
        .o_strobe_rise(strb_rise),
        .o_strobe_fall(strb_fall),
        .o_rw_rise(rw_rise),
        .o_rw_held(rw_held),
        .o_ad_held(ad_held)
    );

    // ****************************************
    // reset input synchroniser
    // ****************************************
    logic rst_meta_reg, rst_sync_reg, rst_seen_reg;
    logic reset_active;

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
            rst_seen_reg <= 1'b0;
        end else begin
            rst_meta_reg <= i_reset_n;
            rst_sync_reg <= rst_meta_reg; // [RQ17]
            rst_seen_reg <= rst_sync_reg;
        end
    end

    // clears act only with good supply; power fail alone clears nothing
    always_comb begin
        reset_active = ~rst_sync_reg & i_power_ok; // [RQ13] [RQ17]
    end

    // ****************************************
    // host bus port
    // ****************************************
    logic [7:0] addr_reg, addr_next;
    logic addr_valid_reg, addr_valid_next;
    logic [7:0] ad_out_reg, ad_out_next;
    logic ad_oe_reg, ad_oe_next;
    logic access_ok, rd_win, rd_end, wr_take;
    logic [7:0] ctrl_reg, flag_reg;
    logic irq_flag;

    always_comb begin
        addr_next = addr_reg;
        addr_valid_next = addr_valid_reg;
        if (as_rise) begin
            addr_valid_next = 1'b0;
        end
        if (as_fall) begin
            addr_next = i_ad; // [RQ14]
            addr_valid_next = 1'b1;
        end
        // no access while reset is low, supply is bad or chip not selected
        access_ok = rst_sync_reg & i_power_ok & ~i_chip_select_n
            & addr_valid_reg; // [RQ10]
        if (i_bus_style_select) begin // [RQ1]
            rd_win = i_data_read_strobe & i_read_write; // [RQ3]
            rd_end = strb_fall & rw_held;
            wr_take = strb_fall & ~rw_held; // [RQ4]
        end else begin
            rd_win = ~i_data_read_strobe & i_read_write; // [RQ5]
            rd_end = strb_rise & rw_held;
            wr_take = rw_rise; // [RQ15]
        end
        rd_end = rd_end & access_ok;
        wr_take = wr_take & access_ok;
        ad_oe_next = rd_win & access_ok;
        case (addr_reg)
            HB_CTRL_ADDR: ad_out_next = ctrl_reg;
            HB_FLAG_ADDR: begin
                ad_out_next = flag_reg;
                ad_out_next[IRQ_FLAG_BIT] = irq_flag;
            end
            default: ad_out_next = 8'h00;
        endcase
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            addr_reg <= 8'h00;
            addr_valid_reg <= 1'b0;
            ad_out_reg <= 8'h00;
            ad_oe_reg <= 1'b0;
        end else begin
            addr_reg <= addr_next;
            addr_valid_reg <= addr_valid_next;
            ad_out_reg <= ad_out_next;
            ad_oe_reg <= ad_oe_next;
        end
    end

    // ****************************************
    // control, flags and request pin
    // ****************************************
    logic [7:0] ctrl_next, flag_next;
    logic irq_oe_reg, irq_oe_next;
    logic irq_flag_next;
    logic avs_take;
    logic avs_wr_ctrl;

    always_comb begin
        irq_flag = (flag_reg[PER_FLAG_BIT] & ctrl_reg[PER_IE_BIT])
            | (flag_reg[ALM_FLAG_BIT] & ctrl_reg[ALM_IE_BIT])
            | (flag_reg[UPD_FLAG_BIT] & ctrl_reg[UPD_IE_BIT]);
        ctrl_next = ctrl_reg;
        if (avs_wr_ctrl) begin
            ctrl_next = i_avs_writedata[7:0];
        end
        if (wr_take && addr_reg == HB_CTRL_ADDR) begin
            ctrl_next = ad_held;
        end
        flag_next = flag_reg;
        if (rd_end && addr_reg == HB_FLAG_ADDR) begin
            flag_next = FLAG_RESET; // [RQ16]
        end
        // a new event in the clearing cycle still sets its flag
        if (i_periodic_event) begin
            flag_next[PER_FLAG_BIT] = 1'b1;
        end
        if (i_alarm_event) begin
            flag_next[ALM_FLAG_BIT] = 1'b1;
        end
        if (i_update_event) begin
            flag_next[UPD_FLAG_BIT] = 1'b1;
        end
        // only these bits react to reset; time and ram sit elsewhere [RQ6]
        if (reset_active) begin
            ctrl_next[PER_IE_BIT] = 1'b0; // [RQ7]
            ctrl_next[ALM_IE_BIT] = 1'b0; // [RQ7]
            ctrl_next[UPD_IE_BIT] = 1'b0; // [RQ7]
            ctrl_next[SQW_EN_BIT] = 1'b0; // [RQ11]
            flag_next[PER_FLAG_BIT] = 1'b0; // [RQ8]
            flag_next[ALM_FLAG_BIT] = 1'b0; // [RQ8]
        end
        irq_flag_next = (flag_next[PER_FLAG_BIT] & ctrl_next[PER_IE_BIT])
            | (flag_next[ALM_FLAG_BIT] & ctrl_next[ALM_IE_BIT])
            | (flag_next[UPD_FLAG_BIT] & ctrl_next[UPD_IE_BIT]); // [RQ8]
        irq_oe_next = irq_flag_next & ~reset_active; // [RQ9]
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            ctrl_reg <= CTRL_RESET;
            flag_reg <= FLAG_RESET;
            irq_oe_reg <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            flag_reg <= flag_next;
            irq_oe_reg <= irq_oe_next;
        end
    end

    // ****************************************
    // avalon slave and system interrupt
    // ****************************************
    avs_state_e avs_state_reg, avs_state_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [EV_W-1:0] ev_reg, ev_next, ev_set;
    logic [EV_W-1:0] mask_reg, mask_next;
    logic sys_irq_reg, sys_irq_next;

    always_comb begin
        avs_state_next = avs_state_reg;
        rdata_next = rdata_reg;
        mask_next = mask_reg;
        avs_take = 1'b0;
        case (avs_state_reg)
            AVS_IDLE: begin
                if (i_avs_read || i_avs_write) begin
                    avs_state_next = AVS_ANSWER;
                end
                rdata_next = 32'h0000_0000;
                case (i_avs_address)
                    AVS_CTRL: rdata_next[7:0] = ctrl_reg;
                    AVS_STAT: begin
                        rdata_next[7:0] = flag_reg;
                        rdata_next[IRQ_FLAG_BIT] = irq_flag;
                        rdata_next[STAT_ACCESS_BIT] = rst_sync_reg;
                        rdata_next[STAT_STYLE_BIT] = i_bus_style_select;
                        rdata_next[STAT_POWER_BIT] = i_power_ok;
                        rdata_next[STAT_IRQ_BIT] = irq_oe_reg;
                    end
                    AVS_INT: rdata_next[EV_W-1:0] = ev_reg;
                    AVS_MASK: rdata_next[EV_W-1:0] = mask_reg;
                    default: rdata_next = 32'h0000_0000;
                endcase
            end
            AVS_ANSWER: begin
                avs_take = 1'b1;
                avs_state_next = AVS_IDLE;
                if (i_avs_write && i_avs_address == AVS_MASK) begin
                    mask_next = i_avs_writedata[EV_W-1:0];
                end
            end
            default: avs_state_next = AVS_IDLE;
        endcase
        avs_wr_ctrl = avs_take & i_avs_write & (i_avs_address == AVS_CTRL);
        ev_set = EV_RESET;
        ev_set[EV_WR] = wr_take;
        ev_set[EV_RD] = rd_end;
        ev_set[EV_RST] = rst_seen_reg & ~rst_sync_reg;
        ev_set[EV_IRQ] = irq_oe_next & ~irq_oe_reg;
        ev_next = ev_reg;
        // clear only the reported bits, so an event after the load is kept
        if (avs_take && i_avs_read && i_avs_address == AVS_INT) begin
            ev_next = ev_reg & ~rdata_reg[EV_W-1:0];
        end
        ev_next = ev_next | ev_set;
        sys_irq_next = |(ev_next & mask_next);
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            avs_state_reg <= AVS_IDLE;
            rdata_reg <= 32'h0000_0000;
            ev_reg <= EV_RESET;
            mask_reg <= EV_RESET;
            sys_irq_reg <= 1'b0;
        end else begin
            avs_state_reg <= avs_state_next;
            rdata_reg <= rdata_next;
            ev_reg <= ev_next;
            mask_reg <= mask_next;
            sys_irq_reg <= sys_irq_next;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    always_comb begin
        o_ad = ad_out_reg;
        o_ad_oe = ad_oe_reg;
        o_irq_n_out = 1'b0;
        o_irq_n_oe = irq_oe_reg;
        o_square_wave_enable = ctrl_reg[SQW_EN_BIT];
        o_avs_readdata = rdata_reg;
        o_avs_waitrequest = (avs_state_reg != AVS_ANSWER);
        o_irq = sys_irq_reg;
    end

endmodule

// *** sim/rtc_port_monitor.sv ***
// Purpose: port checker for the rtc host strobe and reset block
// Assumes: one clock, reset active high
// Notes: bound to the top module
`timescale 1ns/1ps
module rtc_port_monitor (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_bus_style_select,
    input wire logic i_data_read_strobe,
    input wire logic i_read_write,
    input wire logic i_reset_n,
    input wire logic i_power_ok,
    input wire logic i_avs_write,
    input wire logic i_chip_select_n,
    input wire logic i_periodic_event,
    input wire logic i_alarm_event,
    input wire logic i_update_event,
    input wire logic o_ad_oe,
    input wire logic o_irq_n_out,
    input wire logic o_irq_n_oe,
    input wire logic o_square_wave_enable
);
    // ****
    // port checks
    // ****
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    property p_strobe_read;
        o_ad_oe && $past(i_bus_style_select) |-> $past(i_data_read_strobe) && $past(i_read_write);
    endproperty
    a_strobe_read: assert property (p_strobe_read) else $error("bus driven outside strobe");
    property p_oe_read;
        o_ad_oe && !$past(i_bus_style_select) |-> !$past(i_data_read_strobe) && $past(i_read_write);
    endproperty
    a_oe_read: assert property (p_oe_read) else $error("bus driven outside enable");
    property p_no_access; (!i_reset_n)[*5] |-> !o_ad_oe; endproperty
    a_no_access: assert property (p_no_access) else $error("bus driven in reset");
    property p_irq_release; (!i_reset_n && i_power_ok)[*5] |-> !o_irq_n_oe; endproperty
    a_irq_release: assert property (p_irq_release) else $error("irq held in reset");
    property p_irq_rise; $rose(o_irq_n_oe) && $past(i_power_ok) |-> $past(i_reset_n, 3); endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("irq raised in reset");
    property p_open_drain; o_irq_n_out == 1'b0; endproperty
    a_open_drain: assert property (p_open_drain) else $error("irq drives high");
    property p_irq_cause;
        $rose(o_irq_n_oe) |-> $past(i_periodic_event || i_alarm_event || i_update_event
            || i_avs_write || !i_chip_select_n);
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("irq raised without cause");
    property p_square_wave_enable_clear; (!i_reset_n && i_power_ok)[*5] |=> !o_square_wave_enable; endproperty
    a_square_wave_enable_clear: assert property (p_square_wave_enable_clear) else $error("square wave kept in reset");
    property p_power_hold;
        !i_power_ok && !$past(i_power_ok) && !$past(i_power_ok, 2) && !$past(i_avs_write)
            && !$past(i_avs_write, 2) |-> $stable(o_square_wave_enable);
    endproperty
    a_power_hold: assert property (p_power_hold) else $error("power fail changed ctrl");
    property p_sync_delay;
        $fell(i_reset_n) && !i_avs_write && !$past(i_avs_write) |=> $stable(o_square_wave_enable);
    endproperty
    a_sync_delay: assert property (p_sync_delay) else $error("reset not synchronised");
    c_strobe_read: cover property (o_ad_oe && i_bus_style_select);
    c_oe_read: cover property (o_ad_oe && !i_bus_style_select);
    c_reset_clear: cover property ($fell(o_square_wave_enable) && !i_reset_n);
endmodule
bind rtc_bus_strobe_and_reset rtc_port_monitor u_mon (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_bus_style_select(i_bus_style_select),
    .i_data_read_strobe(i_data_read_strobe), .i_read_write(i_read_write),
    .i_reset_n(i_reset_n), .i_power_ok(i_power_ok), .i_avs_write(i_avs_write),
    .i_chip_select_n(i_chip_select_n), .i_periodic_event(i_periodic_event),
    .i_alarm_event(i_alarm_event), .i_update_event(i_update_event),
    .o_ad_oe(o_ad_oe), .o_irq_n_out(o_irq_n_out), .o_irq_n_oe(o_irq_n_oe),
    .o_square_wave_enable(o_square_wave_enable)
);

// *** sim/rtc_host_model.sv ***
// Purpose: host processor on the multiplexed bus
// Assumes: bench calls xfer; strobe and write levels held two cycles or more, chip select high only one cycle between back-to-back calls
// Notes: a released bus shows the inverse of the last host value
`timescale 1ns/1ps
module rtc_host_model (
    input wire logic i_mclk,
    input wire logic i_style,
    input wire logic [7:0] i_dev_ad,
    input wire logic i_dev_oe,
    output logic o_as = 1'b0,
    output logic o_strobe,
    output logic o_rw,
    output logic o_cs_n = 1'b1,
    output logic [7:0] o_bus
);
    logic [7:0] h_ad = 8'h00;
    logic h_oe = 1'b0;
    logic strobe_on = 1'b0;
    logic wr_on = 1'b0;
    // ****
    // pin levels and cycles
    // ****
    assign o_strobe = i_style ? strobe_on : !strobe_on;
    assign o_rw = !wr_on;
    assign o_bus = i_dev_oe ? i_dev_ad : (h_oe ? h_ad : ~h_ad);
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] wd,
        output logic [7:0] rd);
        @(posedge i_mclk);
        o_cs_n <= 1'b0;
        o_as <= 1'b1;
        h_oe <= 1'b1;
        h_ad <= a;
        repeat (2) @(posedge i_mclk);
        o_as <= 1'b0;
        repeat (2) @(posedge i_mclk);
        h_oe <= wr;
        h_ad <= wd;
        wr_on <= wr;
        strobe_on <= !wr || i_style;
        repeat (4) @(posedge i_mclk);
        rd = o_bus;
        strobe_on <= 1'b0;
        if (!i_style) begin
            wr_on <= 1'b0;
        end
        repeat (2) @(posedge i_mclk);
        wr_on <= 1'b0;
        o_cs_n <= 1'b1;
        h_oe <= 1'b0;
    endtask
endmodule

// *** sim/rtc_bus_strobe_and_reset_bench.sv ***
// Purpose: self-checking bench for the rtc host strobe and reset block
// Assumes: 200 MHz clock, host bus through the host model
// Notes: registers reached over avalon
`timescale 1ns/1ps
module rtc_bus_strobe_and_reset_bench;
    import rtc_port_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic style = 1'b1;
    logic reset_n = 1'b1;
    logic power_ok = 1'b1;
    logic [2:0] ev = 3'h0;
    logic [3:0] adr = 4'h0;
    logic rd_en = 1'b0;
    logic wr_en = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic [31:0] avs_rd;
    logic wait_req, irq, ad_oe, irq_oe, square_wave_enable, as_s, strobe_s, rw_s, cs_n;
    logic [7:0] bus, dev_ad, hd;
    int num_errors = 0;
    int n_compared = 0;
    rtc_bus_strobe_and_reset u_dut (
        .i_mclk(clk), .i_rst(rst), .i_bus_style_select(style),
        .i_address_latch_strobe(as_s), .i_data_read_strobe(strobe_s), .i_read_write(rw_s),
        .i_chip_select_n(cs_n), .i_reset_n(reset_n), .i_power_ok(power_ok), .i_ad(bus),
        .o_ad(dev_ad), .o_ad_oe(ad_oe), .o_irq_n_out(), .o_irq_n_oe(irq_oe),
        .o_square_wave_enable(square_wave_enable), .i_periodic_event(ev[0]), .i_alarm_event(ev[1]),
        .i_update_event(ev[2]), .i_avs_address(adr), .i_avs_read(rd_en),
        .i_avs_write(wr_en), .i_avs_writedata(wdata), .o_avs_readdata(avs_rd),
        .o_avs_waitrequest(wait_req), .o_irq(irq)
    );
    rtc_host_model u_host (
        .i_mclk(clk), .i_style(style), .i_dev_ad(dev_ad), .i_dev_oe(ad_oe),
        .o_as(as_s), .o_strobe(strobe_s), .o_rw(rw_s), .o_cs_n(cs_n), .o_bus(bus)
    );
    // ****
    // tasks
    // ****
    task automatic finish_test();
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask
    task automatic avs(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        adr <= a;
        wr_en <= wr;
        rd_en <= !wr;
        wdata <= d;
        @(posedge clk);
        while (wait_req !== 1'b0 && n < 50) begin
            @(posedge clk);
            n++;
        end
        rdata = avs_rd;
        rd_en <= 1'b0;
        wr_en <= 1'b0;
        if (n == 50) begin
            num_errors++;
            finish_test();
        end
    endtask
    task automatic ard(input logic [3:0] a, input logic [31:0] exp);
        avs(1'b0, a, 32'h0);
        chk(rdata, exp);
    endtask
    // ****
    // sequence
    // ****
    initial begin
        forever #2.5 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        finish_test();
    end
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        ard(AVS_STAT, 32'h700);
        ard(AVS_CTRL, {24'h0, CTRL_RESET});
        ard(4'h2, 32'h0);
        avs(1'b0, AVS_INT, 32'h0);
        avs(1'b1, AVS_MASK, 32'hf);
        u_host.xfer(1'b1, HB_CTRL_ADDR, 8'h78, hd);
        chk_bit(square_wave_enable, 1'b1);
        ard(AVS_CTRL, 32'h78);
        chk_bit(irq, 1'b1);
        ard(AVS_INT, 32'h1);
        repeat (2) @(posedge clk);
        chk_bit(irq, 1'b0);
        u_host.xfer(1'b0, HB_CTRL_ADDR, 8'h00, hd);
        chk({24'h0, hd}, 32'h78);
        ev <= 3'h1;
        @(posedge clk);
        ev <= 3'h0;
        repeat (2) @(posedge clk);
        chk_bit(irq_oe, 1'b1);
        u_host.xfer(1'b0, HB_FLAG_ADDR, 8'h00, hd);
        chk({24'h0, hd}, 32'hc0);
        ard(AVS_STAT, 32'h700);
        ard(AVS_INT, 32'ha);
        avs(1'b1, AVS_CTRL, 32'hff);
        ev <= 3'h6;
        @(posedge clk);
        ev <= 3'h0;
        reset_n <= 1'b0;
        u_host.xfer(1'b1, HB_CTRL_ADDR, 8'h00, hd);
        chk_bit(irq_oe, 1'b0);
        chk_bit(square_wave_enable, 1'b0);
        ard(AVS_STAT, 32'h610);
        ard(AVS_CTRL, 32'h87);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk);
        ard(AVS_INT, 32'hc);
        avs(1'b1, AVS_CTRL, 32'h6f);
        power_ok <= 1'b0;
        u_host.xfer(1'b1, HB_CTRL_ADDR, 8'h00, hd);
        power_ok <= 1'b1;
        ard(AVS_CTRL, 32'h6f);
        avs(1'b1, AVS_MASK, 32'h0);
        style <= 1'b0;
        repeat (2) @(posedge clk);
        ard(AVS_STAT, 32'h510);
        u_host.xfer(1'b1, HB_CTRL_ADDR, 8'h41, hd);
        chk_bit(square_wave_enable, 1'b0);
        chk_bit(irq, 1'b0);
        u_host.xfer(1'b0, HB_CTRL_ADDR, 8'h00, hd);
        chk({24'h0, hd}, 32'h41);
        finish_test();
    end
endmodule
